//--- pkg/eeprom_group_ecc_defs.svh
// Constants for the group error-correction block between command decoder and array.
// Contract
// [R1] Correction adds no serial-visible change to formats, byte order or cycle counts.
// [R2] Any single flipped bit in a four-byte group is corrected on every read.
// [R3] Groups are four bytes aligned, sharing upper address bits, low two bits 0..3.
// [R4] A lone byte write rewrites the other three group bytes and fresh check bits.
// [R5] Host keeps total programming cycles per group below the rated endurance.
// [R6] Host drives address bit fifteen as zero; fifteen bits select the array.
// [R7] Every completed write instruction launches exactly one internal programming cycle.
// [R8] Status byte reads all ones while programming, including group rewrites, runs.
// [R9] One write touches at most one page; all its groups finish in one cycle.
// [R10] Several new bytes in one group merge and that group is programmed once.
`ifndef EEPROM_GROUP_ECC_DEFS_SVH
`define EEPROM_GROUP_ECC_DEFS_SVH
`define ECC_ADDR_W 15
`define ECC_GRP_W 13
`define ECC_PAGE_W 8
`define ECC_GIDX_W 5
`define ECC_PAGE_BYTES 128
`define ECC_PAGE_GROUPS 32
`define ECC_LAST_GIDX 5'h1f
`define ECC_CHK_W 6
`define ECC_DATA_W 32
`define ECC_STATUS_BUSY 8'hff
`endif

//--- pkg/eeprom_group_ecc_pkg.sv
// Types shared by the group error-correction block.
`include "eeprom_group_ecc_defs.svh"
package eeprom_group_ecc_pkg;
	// One stored group: four data bytes and their check bits.
	typedef struct packed {
		logic [`ECC_CHK_W-1:0] chk;
		logic [`ECC_DATA_W-1:0] data;
	} grp_word_t;

	// Request to the nonvolatile array.
	typedef struct packed {
		logic req;
		logic we;
		logic [`ECC_GRP_W-1:0] grp;
	} arr_cmd_t;

	typedef enum {ST_IDLE, ST_RD, ST_SCAN, ST_FETCH, ST_PROG} ecc_state_t;
endpackage : eeprom_group_ecc_pkg

//--- verilog/eeprom_group_ecc.sv
// Group error-correction engine between the serial command decoder and the array.
`timescale 1ns/10ps
`include "eeprom_group_ecc_defs.svh"
module eeprom_group_ecc (
	// Clock, reset and enable.
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// Read requests from the decoder.
	input wire logic rd_req_in,
	input wire logic [`ECC_ADDR_W-1:0] rd_addr_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic ecc_fix_out,
	// Write bytes and instruction end from the decoder.
	input wire logic wr_byte_in,
	input wire logic [`ECC_ADDR_W-1:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_commit_in,
	input wire logic wr_discard_in,
	// Status path.
	input wire logic [7:0] status_in,
	output logic [7:0] status_out,
	output logic busy_out,
	// Array port.
	output eeprom_group_ecc_pkg::arr_cmd_t arr_cmd_out,
	output eeprom_group_ecc_pkg::grp_word_t arr_wdata_out,
	input wire eeprom_group_ecc_pkg::grp_word_t arr_rdata_in,
	input wire logic arr_ack_in
);
	import eeprom_group_ecc_pkg::*;

	// Hamming position of data bit i, skipping the power-of-two check positions.
	function automatic logic [`ECC_CHK_W-1:0] bit_pos(input int i);
		int n;
		logic [`ECC_CHK_W-1:0] r;
		n = 0;
		r = '0;
		for (int k = 3; k < 40; k++) begin
			if ((k & (k - 1)) != 0) begin
				if (n == i) r = k[`ECC_CHK_W-1:0];
				n++;
			end
		end
		return r;
	endfunction : bit_pos

	// Check bits over the four data bytes of a group.
	function automatic logic [`ECC_CHK_W-1:0] chk_gen(input logic [`ECC_DATA_W-1:0] d);
		logic [`ECC_CHK_W-1:0] c;
		logic [`ECC_CHK_W-1:0] p;
		c = '0;
		for (int i = 0; i < `ECC_DATA_W; i++) begin
			p = bit_pos(i);
			for (int j = 0; j < `ECC_CHK_W; j++) begin
				if (p[j]) c[j] = c[j] ^ d[i];
			end
		end
		return c;
	endfunction : chk_gen

	ecc_state_t state_r, state_nxt;
	logic [`ECC_GRP_W-1:0] rgrp_r, rgrp_nxt;
	logic [1:0] rbyte_r, rbyte_nxt;
	logic [`ECC_PAGE_W-1:0] page_r, page_nxt;
	logic [`ECC_GIDX_W-1:0] gidx_r, gidx_nxt;
	logic [7:0] pbuf_r [`ECC_PAGE_BYTES];
	logic [7:0] pbuf_nxt [`ECC_PAGE_BYTES];
	logic [`ECC_PAGE_BYTES-1:0] pmask_r, pmask_nxt;
	grp_word_t wword_r, wword_nxt;
	logic [`ECC_DATA_W-1:0] cache_r, cache_nxt;
	logic [`ECC_GRP_W-1:0] cgrp_r, cgrp_nxt;
	logic cvld_r, cvld_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic fix_r, fix_nxt;
	logic [7:0] status_r, status_nxt;
	logic [`ECC_CHK_W-1:0] syndrome;
	logic [`ECC_DATA_W-1:0] fixed;
	logic [`ECC_DATA_W-1:0] merged;
	logic [3:0] gmask;
	logic prog_busy;

	// Syndrome of the word the array returns; it points at the flipped data bit.
	assign syndrome = arr_rdata_in.chk ^ chk_gen(arr_rdata_in.data); // [R2]

	// Per-bit correction and merge of buffered bytes into the fetched group.
	for (genvar b = 0; b < `ECC_DATA_W; b++) begin : g_bit
		// Byte lane and bit within the lane, kept as constants so no genvar is sliced.
		localparam logic [1:0] LANE = 2'(b / 8);
		localparam logic [2:0] LBIT = 3'(b % 8);
		assign fixed[b] = arr_rdata_in.data[b] ^ (syndrome == bit_pos(b)); // [R2]
		assign merged[b] = pmask_r[{gidx_r, LANE}] ?
			pbuf_r[{gidx_r, LANE}][LBIT] : fixed[b]; // [R4] [R10]
	end
	assign gmask = pmask_r[{gidx_r, 2'b00} +: 4];
	assign prog_busy = (state_r == ST_SCAN) || (state_r == ST_FETCH) || (state_r == ST_PROG);

	// Array request; held until the array acknowledges.
	always_comb begin
		arr_cmd_out.req = (state_r == ST_RD) || (state_r == ST_FETCH) || (state_r == ST_PROG);
		arr_cmd_out.we = (state_r == ST_PROG);
		arr_cmd_out.grp = (state_r == ST_RD) ? rgrp_r : {page_r, gidx_r}; // [R3]
	end
	assign arr_wdata_out = wword_r;

	// Next-state logic for the sequencer, page buffer, group cache and outputs.
	always_comb begin
		state_nxt = state_r;
		rgrp_nxt = rgrp_r;
		rbyte_nxt = rbyte_r;
		page_nxt = page_r;
		gidx_nxt = gidx_r;
		pbuf_nxt = pbuf_r;
		pmask_nxt = pmask_r;
		wword_nxt = wword_r;
		cache_nxt = cache_r;
		cgrp_nxt = cgrp_r;
		cvld_nxt = cvld_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		fix_nxt = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				// Bytes land at their in-page offset, so a wrapped page keeps the last 128.
				if (wr_byte_in) begin
					if (pmask_r == '0) page_nxt = wr_addr_in[`ECC_ADDR_W-1:7]; // [R9]
					pbuf_nxt[wr_addr_in[6:0]] = wr_data_in;
					pmask_nxt[wr_addr_in[6:0]] = 1'b1;
				end
				if (wr_discard_in) begin
					pmask_nxt = '0;
				end else if (wr_commit_in && (pmask_r != '0 || wr_byte_in)) begin
					gidx_nxt = '0;
					cvld_nxt = 1'b0;
					state_nxt = ST_SCAN; // [R7]
				end else if (rd_req_in) begin
					// A cached group answers at once; bytes of a group come out corrected.
					if (cvld_r && cgrp_r == rd_addr_in[`ECC_ADDR_W-1:2]) begin
						rdata_nxt = cache_r[{rd_addr_in[1:0], 3'b000} +: 8]; // [R2]
						rvalid_nxt = 1'b1;
					end else begin
						rgrp_nxt = rd_addr_in[`ECC_ADDR_W-1:2]; // [R3]
						rbyte_nxt = rd_addr_in[1:0];
						state_nxt = ST_RD;
					end
				end
			end
			ST_RD: begin
				if (arr_ack_in) begin
					cache_nxt = fixed;
					cgrp_nxt = rgrp_r;
					cvld_nxt = 1'b1;
					rdata_nxt = fixed[{rbyte_r, 3'b000} +: 8]; // [R2]
					rvalid_nxt = 1'b1;
					fix_nxt = (syndrome != '0);
					state_nxt = ST_IDLE;
				end
			end
			ST_SCAN: begin
				// Untouched groups are skipped so no group is worn needlessly.
				if (gmask != 4'h0) begin
					state_nxt = ST_FETCH; // [R9]
				end else if (gidx_r == `ECC_LAST_GIDX) begin
					pmask_nxt = '0;
					state_nxt = ST_IDLE;
				end else begin
					gidx_nxt = gidx_r + 1'b1;
				end
			end
			ST_FETCH: begin
				if (arr_ack_in) begin
					wword_nxt.data = merged; // [R4] [R10]
					wword_nxt.chk = chk_gen(merged); // [R4]
					state_nxt = ST_PROG;
				end
			end
			ST_PROG: begin
				// Each touched group is written exactly once per instruction.
				if (arr_ack_in) begin
					if (gidx_r == `ECC_LAST_GIDX) begin
						pmask_nxt = '0;
						state_nxt = ST_IDLE;
					end else begin
						gidx_nxt = gidx_r + 1'b1;
						state_nxt = ST_SCAN; // [R10]
					end
				end
			end
		endcase
		status_nxt = (state_nxt != ST_IDLE && state_nxt != ST_RD) ?
			`ECC_STATUS_BUSY : status_in; // [R8]
	end

	// Register stage; clock enable low freezes everything.
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_IDLE;
			rgrp_r <= '0;
			rbyte_r <= '0;
			page_r <= '0;
			gidx_r <= '0;
			pbuf_r <= '{default: 8'h00};
			pmask_r <= '0;
			wword_r <= '0;
			cache_r <= '0;
			cgrp_r <= '0;
			cvld_r <= 1'b0;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			fix_r <= 1'b0;
			status_r <= 8'h00;
		end else if (clk_en_in) begin
			state_r <= state_nxt;
			rgrp_r <= rgrp_nxt;
			rbyte_r <= rbyte_nxt;
			page_r <= page_nxt;
			gidx_r <= gidx_nxt;
			pbuf_r <= pbuf_nxt;
			pmask_r <= pmask_nxt;
			wword_r <= wword_nxt;
			cache_r <= cache_nxt;
			cgrp_r <= cgrp_nxt;
			cvld_r <= cvld_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			fix_r <= fix_nxt;
			status_r <= status_nxt;
		end
	end

	// Read outputs and status_out come straight from flops, busy_out is decoded from state_r, so the serial timing never sees correction.
	assign rd_data_out = rdata_r; // [R1]
	assign rd_valid_out = rvalid_r;
	assign ecc_fix_out = fix_r;
	assign status_out = status_r; // [R8]
	assign busy_out = prog_busy;
endmodule : eeprom_group_ecc

//--- sim/eeprom_group_ecc_asserts.sv
// Checker for the port behaviour of the group error-correction block.
`timescale 1ns/10ps
`include "eeprom_group_ecc_defs.svh"
module eeprom_group_ecc_chk import eeprom_group_ecc_pkg::*; (
	// Control and handshake bits.
	input wire logic core_clk_in, rst_n_in, clk_en_in, rd_req_in, rd_valid_out, ecc_fix_out,
	input wire logic wr_byte_in, wr_commit_in, wr_discard_in, busy_out, arr_ack_in,
	// Addresses and bytes.
	input wire logic [`ECC_ADDR_W-1:0] rd_addr_in, wr_addr_in,
	input wire logic [7:0] rd_data_out, wr_data_in, status_in, status_out,
	// Array port.
	input wire arr_cmd_t arr_cmd_out,
	input wire grp_word_t arr_wdata_out, arr_rdata_in
);
	// Everything samples on the rising edge and rests while reset is low.
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Short names for the array request bits.
	wire logic rq = arr_cmd_out.req;
	wire logic wr = arr_cmd_out.we;
	a_status_ones:
	assert property (busy_out |-> status_out == `ECC_STATUS_BUSY) else $error("status not ones");
	a_busy_cause:
	assert property ($rose(busy_out) |-> $past(wr_commit_in)) else $error("busy without commit");
	a_fetch_prog:
	assert property (rq && !wr && arr_ack_in && busy_out |=> rq && wr
		&& arr_cmd_out.grp == $past(arr_cmd_out.grp)) else $error("group not rewritten");
	a_prog_once:
	assert property (rq && wr && arr_ack_in |=> !(rq && wr)) else $error("group written twice");
	a_read_group:
	assert property ($rose(rq) && !busy_out |-> arr_cmd_out.grp ==
		$past(rd_addr_in[`ECC_ADDR_W-1:2])) else $error("wrong read group");
	a_read_answer:
	assert property (rq && !wr && arr_ack_in && !busy_out |=> rd_valid_out) else $error("late read");
	a_fix_valid:
	assert property (ecc_fix_out |-> rd_valid_out) else $error("fix flag without data");
	a_busy_bound:
	assert property ($rose(busy_out) |-> ##[1:1000] !busy_out) else $error("programming hangs");
	// Main scenarios: corrected read, group write, cache hit.
	cover property (ecc_fix_out);
	cover property (rq && wr && arr_ack_in);
	cover property (rd_valid_out && !$past(rq));
endmodule : eeprom_group_ecc_chk
bind eeprom_group_ecc eeprom_group_ecc_chk eeprom_group_ecc_chk_i (.*);

//--- sim/ecc_array_model.sv
// Behavioural nonvolatile array that answers the block's group requests.
`timescale 1ns/10ps
module ecc_array_model import eeprom_group_ecc_pkg::*; (
	// Clock, reset and answer delay.
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] lag_in,
	// Request side.
	input wire arr_cmd_t arr_cmd_out,
	input wire grp_word_t arr_wdata_out,
	// Answer side.
	output grp_word_t arr_rdata_in,
	output logic arr_ack_in
);
	// Erased groups hold zero data and zero check bits, which is a valid code word.
	grp_word_t mem [0:8191] = '{default: '0};
	logic [3:0] cnt_r;
	// Answer lag_in+1 cycles after the request appears; data toggles with no request and after each answer, holds while counting, so stale use shows.
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			arr_ack_in <= 1'h0;
			cnt_r <= 4'h0;
			arr_rdata_in <= '1;
		end else if (arr_ack_in || !arr_cmd_out.req) begin
			arr_ack_in <= 1'h0;
			cnt_r <= 4'h0;
			arr_rdata_in <= ~arr_rdata_in;
		end else if (cnt_r == lag_in) begin
			arr_ack_in <= 1'h1;
			if (arr_cmd_out.we) begin
				mem[arr_cmd_out.grp] <= arr_wdata_out; // One cycle per group write.
			end else begin
				arr_rdata_in <= mem[arr_cmd_out.grp];
			end
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule : ecc_array_model

//--- sim/testbench.sv
// Self-checking bench for the group error-correction block.
`timescale 1ns/10ps
module testbench;
	import eeprom_group_ecc_pkg::*;
	logic core_clk_in = 1'h0, rst_n_in = 1'h0, clk_en_in = 1'h1, rd_req_in = 1'h0;
	logic wr_byte_in = 1'h0, wr_commit_in = 1'h0, wr_discard_in = 1'h0;
	logic rd_valid_out, ecc_fix_out, busy_out, arr_ack_in;
	logic [14:0] rd_addr_in = 15'h0, wr_addr_in = 15'h0;
	logic [7:0] wr_data_in = 8'h0, status_in = 8'h5a, rd_data_out, status_out;
	logic [3:0] lag_in = 4'h0;
	arr_cmd_t arr_cmd_out;
	grp_word_t arr_wdata_out, arr_rdata_in;
	int err_count = 0, samples_checked = 0, prog_count = 0;
	eeprom_group_ecc eeprom_group_ecc_i (.*);
	ecc_array_model ecc_array_model_i (.*);
	// Clock of 25 ns period.
	always #12.5 core_clk_in = ~core_clk_in;
	// Count group programming cycles seen at the array.
	always @(posedge core_clk_in) if (arr_ack_in && arr_cmd_out.we) prog_count++;
	task chk(input logic [7:0] exp, input logic [7:0] got, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Addresses are fifteen bits wide, so the top serial address bit is always zero.
	task wr_b(input logic [14:0] a, input logic [7:0] d);
		@(negedge core_clk_in) wr_byte_in = 1'h1;
		wr_addr_in = a;
		wr_data_in = d;
		@(negedge core_clk_in) wr_byte_in = 1'h0;
	endtask : wr_b
	task commit(input int groups);
		prog_count = 0;
		@(negedge core_clk_in) wr_commit_in = 1'h1;
		@(negedge core_clk_in) wr_commit_in = 1'h0;
		@(negedge core_clk_in);
		chk(8'hff, status_out, "status busy");
		for (int i = 0; i < 2000 && busy_out !== 1'h0; i++) @(negedge core_clk_in);
		chk(8'h00, {7'h0, busy_out}, "busy end");
		chk(8'(groups), 8'(prog_count), "group writes");
		chk(8'h5a, status_out, "status idle");
	endtask : commit
	task rd(input logic [14:0] a, input logic [7:0] e, input logic f);
		@(negedge core_clk_in) rd_req_in = 1'h1;
		rd_addr_in = a;
		@(negedge core_clk_in) rd_req_in = 1'h0;
		for (int i = 0; i < 60 && rd_valid_out !== 1'h1; i++) @(negedge core_clk_in);
		chk(8'h01, {7'h0, rd_valid_out}, "read valid");
		chk(e, rd_data_out, "read data");
		chk({7'h0, f}, {7'h0, ecc_fix_out}, "fix flag");
	endtask : rd
	// Three bytes over two groups in one instruction; neighbours stay erased.
	task t_page;
		wr_b(15'h0105, 8'ha1);
		wr_b(15'h0106, 8'hb2);
		wr_b(15'h010c, 8'hc3);
		commit(2);
		rd(15'h0104, 8'h00, 1'h0);
		rd(15'h0105, 8'ha1, 1'h0);
		rd(15'h0106, 8'hb2, 1'h0);
		rd(15'h010c, 8'hc3, 1'h0);
		$display("test page done");
	endtask : t_page
	// A lone byte with a slow array keeps the rest of its group.
	task t_lone;
		lag_in = 4'h3;
		wr_b(15'h0107, 8'hd4);
		commit(1);
		rd(15'h0105, 8'ha1, 1'h0);
		rd(15'h0107, 8'hd4, 1'h0);
		$display("test lone byte done");
	endtask : t_lone
	// A flipped stored bit is corrected on a miss; the following hit reads another byte of that group.
	task t_fix;
		rd(15'h010c, 8'hc3, 1'h0);
		ecc_array_model_i.mem[13'h0041].data[13] = 1'h0;
		rd(15'h0105, 8'ha1, 1'h1);
		rd(15'h0106, 8'hb2, 1'h0);
		$display("test correction done");
	endtask : t_fix
	// A discarded byte and a byte sent while frozen leave nothing to program.
	task t_drop;
		wr_b(15'h0105, 8'h77);
		@(negedge core_clk_in) wr_discard_in = 1'h1;
		@(negedge core_clk_in) wr_discard_in = 1'h0;
		clk_en_in = 1'h0;
		wr_b(15'h0106, 8'h66);
		@(negedge core_clk_in) clk_en_in = 1'h1;
		wr_commit_in = 1'h1;
		@(negedge core_clk_in) wr_commit_in = 1'h0;
		@(negedge core_clk_in);
		chk(8'h00, {7'h0, busy_out}, "busy after drop");
		chk(8'h5a, status_out, "status after drop");
		rd(15'h0105, 8'ha1, 1'h0);
		rd(15'h0106, 8'hb2, 1'h0);
		$display("test discard done");
	endtask : t_drop
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	// Main sequence after two cycles of reset.
	initial begin
		repeat (2) @(negedge core_clk_in);
		rst_n_in = 1'h1;
		t_page;
		t_lone;
		t_fix;
		t_drop;
		test_done;
	end
	// Watchdog well beyond the 140 or so cycles the tests need.
	initial begin
		#200000;
		err_count++;
		test_done;
	end
endmodule : testbench
